// >>> logic/eip_consts.vh
// Register map, field positions and reset values of the priority select block
`ifndef EIP_CONSTS_VH
`define EIP_CONSTS_VH

// ---------------------------------------------------------------------------
// Register map
// ---------------------------------------------------------------------------
`define EIP_ADDR_W          12
`define EIP_OFS_PRIORITY    12'h000
`define EIP_OFS_REQUEST     12'h004
`define EIP_OFS_GRANT       12'h008
`define EIP_RST_PRIORITY    8'h00

// ---------------------------------------------------------------------------
// Field positions in the priority register
// ---------------------------------------------------------------------------
`define EIP_BIT_CLOCK_VALID 7
`define EIP_BIT_SECOND_UART 6
`define EIP_BIT_EXT_IRQ7    5
`define EIP_BIT_EXT_IRQ6    4
`define EIP_BIT_CONV1_DONE  3
`define EIP_BIT_TIMER4      2
`define EIP_BIT_CONV0_DONE  1
`define EIP_BIT_TIMER3      0

// ---------------------------------------------------------------------------
// Grant encoding
// ---------------------------------------------------------------------------
`define EIP_NUM_SRC         8
`define EIP_IDX_W           3
`define EIP_IDX_NONE        3'h0

`endif

// >>> logic/eip_priority_select.v
// Extended interrupt priority register with two-level arbitration of eight sources
// What this block does
// - Bits 7..0 rank clock valid, uart 2, irq 7, irq 6, conv 1, timer 4, conv 0, timer 3.
// - A one in a field puts its source at high priority and a zero at low priority.
// - Bit 4 sets only the priority of external interrupt 6 and never its enable.
// - Bit 3 sets converter 1 done to high priority when one, like every other field.

`include "eip_consts.vh"

module eip_priority_select (
  input  wire        clock_in,
  input  wire        rst_b_in,
  input  wire        psel_in,
  input  wire        penable_in,
  input  wire        pwrite_in,
  input  wire [11:0] paddr_in,
  input  wire [31:0] pwdata_in,
  input  wire [3:0]  pstrb_in,
  output wire        pready_out,
  output reg  [31:0] prdata_out,
  output wire        pslverr_out,
  input  wire [7:0]  irq_request_in,
  input  wire        service_done_in,
  output wire [7:0]  priority_level_out,
  output reg         grant_valid_out,
  output reg  [2:0]  grant_index_out,
  output reg         grant_high_out
);

  // -------------------------------------------------------------------------
  // Register state
  // -------------------------------------------------------------------------
  reg  [7:0] extended_irq_priority_one_ff;
  reg  [7:0] nxt_priority;
  reg        active_ff;
  reg        active_high_ff;
  reg  [2:0] active_index_ff;

  // -------------------------------------------------------------------------
  // Address decode
  // -------------------------------------------------------------------------
  // One compare per register, shared by the write path and the read mux
  function hit_of;
    input [11:0] addr;
    input [11:0] ofs;
    begin
      hit_of = (addr == ofs);
    end
  endfunction

  wire       access    = psel_in & penable_in;
  wire       wr_en     = access & pwrite_in;
  wire       rd_setup  = psel_in & ~penable_in & ~pwrite_in;
  wire       hit_prio  = hit_of(paddr_in, `EIP_OFS_PRIORITY);
  wire       hit_req   = hit_of(paddr_in, `EIP_OFS_REQUEST);
  wire       hit_grant = hit_of(paddr_in, `EIP_OFS_GRANT);
  wire       mapped    = hit_prio | hit_req | hit_grant;

  // Zero wait states; unmapped addresses answer with an error
  assign pready_out  = 1'b1;
  assign pslverr_out = access & ~mapped;

  // -------------------------------------------------------------------------
  // Named fields
  // -------------------------------------------------------------------------
  // Built from the field positions so a remap touches only the header
  wire       clock_valid_priority = extended_irq_priority_one_ff[`EIP_BIT_CLOCK_VALID];
  wire       second_uart_priority = extended_irq_priority_one_ff[`EIP_BIT_SECOND_UART];
  wire       ext_irq7_priority    = extended_irq_priority_one_ff[`EIP_BIT_EXT_IRQ7];
  wire       ext_irq6_priority    = extended_irq_priority_one_ff[`EIP_BIT_EXT_IRQ6];
  wire       conv1_done_priority  = extended_irq_priority_one_ff[`EIP_BIT_CONV1_DONE];
  wire       timer4_priority      = extended_irq_priority_one_ff[`EIP_BIT_TIMER4];
  wire       conv0_done_priority  = extended_irq_priority_one_ff[`EIP_BIT_CONV0_DONE];
  wire       timer3_priority      = extended_irq_priority_one_ff[`EIP_BIT_TIMER3];

  // Outputs follow the register directly so arbitration sees a write at once
  assign priority_level_out = {clock_valid_priority, second_uart_priority, ext_irq7_priority,
                               ext_irq6_priority, conv1_done_priority, timer4_priority,
                               conv0_done_priority, timer3_priority};

  // -------------------------------------------------------------------------
  // Priority register
  // -------------------------------------------------------------------------
  // Upper lanes carry no fields, so only strobe lane 0 gates the write
  always @* begin
    nxt_priority = extended_irq_priority_one_ff;
    if (wr_en && hit_prio && pstrb_in[0]) begin
      nxt_priority = pwdata_in[7:0];
    end
  end

  always @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      extended_irq_priority_one_ff <= `EIP_RST_PRIORITY;
    end else begin
      extended_irq_priority_one_ff <= nxt_priority;
    end
  end

  // -------------------------------------------------------------------------
  // Read mux
  // -------------------------------------------------------------------------
  // Loaded in the setup cycle so the word stands through the access phase
  wire [31:0] status_word = {27'h0, active_ff, active_high_ff, active_index_ff};
  reg  [31:0] nxt_prdata;

  always @* begin
    nxt_prdata = prdata_out;
    if (rd_setup) begin
      case ({hit_prio, hit_req, hit_grant})
        3'b100: begin
          nxt_prdata = {24'h00_0000, extended_irq_priority_one_ff};
        end
        3'b010: begin
          nxt_prdata = {24'h00_0000, irq_request_in};
        end
        3'b001: begin
          nxt_prdata = status_word;
        end
        default: begin
          nxt_prdata = 32'h0000_0000;
        end
      endcase
    end
  end

  always @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      prdata_out <= 32'h0000_0000;
    end else begin
      prdata_out <= nxt_prdata;
    end
  end

  // -------------------------------------------------------------------------
  // Arbitration
  // -------------------------------------------------------------------------
  // Lowest index wins a tie, so timer 3 beats everything at its own level
  function [3:0] pick_first;
    input [7:0] req;
    integer i;
    begin
      pick_first = {1'b0, `EIP_IDX_NONE};
      for (i = 7; i >= 0; i = i - 1) begin
        if (req[i]) begin
          pick_first = {1'b1, i[2:0]};
        end
      end
    end
  endfunction

  // Enable masking lives elsewhere; bit 4 feeds only the level split
  wire [7:0] high_req;
  wire [7:0] low_req;
  genvar     g;

  generate
    for (g = 0; g < `EIP_NUM_SRC; g = g + 1) begin : g_split
      assign high_req[g] = irq_request_in[g] & extended_irq_priority_one_ff[g];
      assign low_req[g]  = irq_request_in[g] & ~extended_irq_priority_one_ff[g];
    end
  endgenerate

  wire [3:0] high_pick = pick_first(high_req);
  wire [3:0] low_pick  = pick_first(low_req);

  // -------------------------------------------------------------------------
  // Arbitration state
  // -------------------------------------------------------------------------
  // A service ends on service_done_in or, for a low service, on pre-emption, never when its request drops
  reg        nxt_active;
  reg        nxt_high;
  reg  [2:0] nxt_index;

  always @* begin
    nxt_active = active_ff;
    nxt_high   = active_high_ff;
    nxt_index  = active_index_ff;
    if (active_ff && service_done_in) begin
      nxt_active = 1'b0;
    end
    if (!nxt_active) begin
      if (high_pick[3]) begin
        nxt_active = 1'b1;
        nxt_high   = 1'b1;
        nxt_index  = high_pick[2:0];
      end else if (low_pick[3]) begin
        nxt_active = 1'b1;
        nxt_high   = 1'b0;
        nxt_index  = low_pick[2:0];
      end
    end else if (!active_high_ff && high_pick[3]) begin
      // Pre-emption; a low request never displaces a high service
      nxt_high  = 1'b1;
      nxt_index = high_pick[2:0];
    end
  end

  always @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      active_ff       <= 1'b0;
      active_high_ff  <= 1'b0;
      active_index_ff <= `EIP_IDX_NONE;
    end else begin
      active_ff       <= nxt_active;
      active_high_ff  <= nxt_high;
      active_index_ff <= nxt_index;
    end
  end

  // -------------------------------------------------------------------------
  // Grant outputs
  // -------------------------------------------------------------------------
  // High and index keep their last values while no source is in service
  always @* begin
    grant_valid_out = active_ff;
    grant_high_out  = active_high_ff;
    grant_index_out = active_index_ff;
  end

endmodule // eip_priority_select

// >>> sim/eip_chk_sva.sv
// Port assertions for the priority select block
module eip_chk (
  input wire logic        clock_in,
  input wire logic        rst_b_in,
  input wire logic        psel_in,
  input wire logic        penable_in,
  input wire logic        pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [3:0]  pstrb_in,
  input wire logic [31:0] prdata_out,
  input wire logic        pslverr_out,
  input wire logic [7:0]  irq_request_in,
  input wire logic        service_done_in,
  input wire logic [7:0]  priority_level_out,
  input wire logic        grant_valid_out,
  input wire logic [2:0]  grant_index_out,
  input wire logic        grant_high_out
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clock_in); endclocking
  default disable iff (!rst_b_in);
  wire acc = psel_in && penable_in;
  AST_WR: assert property (
    acc && pwrite_in && paddr_in == 12'h000 && pstrb_in[0]
    |=> priority_level_out == $past(pwdata_in[7:0])) else $error("priority write lost");
  AST_RD: assert property (
    acc && !pwrite_in && paddr_in == 12'h000 |-> prdata_out == {24'h0, priority_level_out})
    else $error("priority read wrong");
  AST_ERR: assert property (
    acc |-> pslverr_out == !(paddr_in == 12'h000 || paddr_in == 12'h004 || paddr_in == 12'h008))
    else $error("error flag wrong");
  AST_LVL: assert property (
    $rose(grant_valid_out) && $stable(priority_level_out)
    |-> grant_high_out == priority_level_out[grant_index_out]) else $error("level wrong");
  AST_PEND: assert property (
    $rose(grant_valid_out) |-> (($past(irq_request_in) >> grant_index_out) & 8'h01) == 8'h01)
    else $error("grant without request");
  AST_HOLD: assert property (
    grant_valid_out && grant_high_out && !service_done_in
    |=> grant_valid_out && grant_high_out && $stable(grant_index_out)) else $error("preempted");
  AST_PX6: assert property (
    priority_level_out == 8'h10 && irq_request_in[4] && !grant_high_out
    |=> grant_high_out && grant_index_out == 3'h4) else $error("high source not taken");
endmodule // eip_chk

bind eip_priority_select eip_chk u_chk (.clock_in, .rst_b_in, .psel_in, .penable_in,
  .pwrite_in, .paddr_in, .pwdata_in, .pstrb_in, .prdata_out, .pslverr_out, .irq_request_in,
  .service_done_in, .priority_level_out, .grant_valid_out, .grant_index_out, .grant_high_out);

// >>> sim/eip_priority_select_test.sv
// Self-checking bench for the priority select block
module eip_priority_select_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock_in = 0, rst_b_in = 0, psel_in = 0, penable_in = 0, pwrite_in = 0;
  logic service_done_in = 0, pready_out, pslverr_out, grant_valid_out, grant_high_out, err;
  logic [11:0] paddr_in = 0;
  logic [31:0] pwdata_in = 0, prdata_out, rd;
  logic [3:0] pstrb_in = 4'hf;
  logic [7:0] irq_request_in = 0, priority_level_out;
  logic [2:0] grant_index_out;
  logic [7:0] rows [5] = '{8'h80, 8'h01, 8'h08, 8'hff, 8'h10};
  int num_errors = 0, n_compared = 0;
  eip_priority_select u_eip_priority_select (.clock_in, .rst_b_in, .psel_in, .penable_in,
    .pwrite_in, .paddr_in, .pwdata_in, .pstrb_in, .pready_out, .prdata_out, .pslverr_out,
    .irq_request_in, .service_done_in, .priority_level_out, .grant_valid_out,
    .grant_index_out, .grant_high_out);
  initial forever #50 clock_in = ~clock_in;
  task chk(input string s, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      num_errors++;
      $display("[FAIL] %s exp %h got %h", s, e, g);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clock_in);
    {psel_in, pwrite_in, paddr_in, pwdata_in} <= {1'b1, w, a, d};
    @(posedge clock_in);
    penable_in <= 1;
    do @(posedge clock_in); while (pready_out !== 1'b1);
    rd = prdata_out;
    err = pslverr_out;
    {psel_in, penable_in} <= 2'b00;
  endtask
  // Request then one edge later the grant flops must show {valid,high,index}
  task arb(input logic [7:0] r, input logic sd, input logic [4:0] e);
    @(posedge clock_in);
    {irq_request_in, service_done_in} <= {r, sd};
    @(posedge clock_in);
    service_done_in <= 0;
    #1 chk("grant", e, {grant_valid_out, grant_high_out, grant_index_out});
  endtask
  task conclude;
    $display("compared %0d errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    #100000 num_errors++;
    conclude;
  end
  initial begin
    repeat (16) @(posedge clock_in);
    rst_b_in <= 1;
    chk("reset", 0, priority_level_out);
    foreach (rows[i]) begin
      apb(1, 12'h000, {24'hffffff, rows[i]});
      apb(0, 12'h000, 0);
      chk("readback", rows[i], rd);
    end
    pstrb_in <= 4'he;
    apb(1, 12'h000, 32'hffff_ffff);
    pstrb_in <= 4'hf;
    #1 chk("strobe", 8'h10, priority_level_out);
    apb(1, 12'h004, 32'hffff_ffff);
    #1 chk("ro write", 8'h10, priority_level_out);
    chk("mapped err", 0, err);
    apb(0, 12'h00c, 0);
    chk("unmapped err", 1, err);
    chk("unmapped data", 0, rd);
    chk("ready", 1, pready_out);
    arb(8'h01, 0, 5'h10);
    arb(8'h11, 0, 5'h1c);
    arb(8'h13, 0, 5'h1c);
    arb(8'h03, 1, 5'h10);
    arb(8'h00, 1, 5'h00);
    apb(1, 12'h000, 8'h08);
    arb(8'h0a, 0, 5'h1b);
    apb(0, 12'h008, 0);
    chk("grant status", 5'h1b, rd);
    apb(0, 12'h004, 0);
    chk("request read", 8'h0a, rd);
    // Mid-run reset must clear the register and the grant
    @(posedge clock_in);
    {irq_request_in, rst_b_in} <= {8'h00, 1'b0};
    #1 chk("reset prio", 0, priority_level_out);
    chk("reset grant", 0, {grant_valid_out, grant_high_out, grant_index_out});
    @(posedge clock_in);
    rst_b_in <= 1;
    apb(0, 12'h000, 0);
    chk("reset read", 0, rd);
    conclude;
  end
endmodule // eip_priority_select_test
